// ### rtl/alu_ops_pkg.sv
// constants, types and opcode decode for the byte/word alu datapath
// assumes one 100 MHz core clock and a 32-bit ahb-lite register bus
package alu_ops_pkg;

    // ***************************************************
    // register map (byte addresses)
    // ***************************************************
    localparam logic [11:0] CMD_OFS = 12'h000;
    localparam logic [11:0] FLAGS_OFS = 12'h004;
    localparam logic [11:0] STATUS_OFS = 12'h008;
    localparam int RF_WINDOW_BIT = 10;
    localparam int CMD_OPC_LSB = 0;
    localparam int CMD_DST_LSB = 8;
    localparam int CMD_SRC_LSB = 16;
    localparam int CMD_GO_BIT = 31;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_BAD_BIT = 1;

    // ***************************************************
    // flag layout and reset values
    // ***************************************************
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] FLAGS_MASK = 8'hfc;

    // ***************************************************
    // opcodes and bcd correction constants
    // ***************************************************
    localparam logic [7:0] OPC_INVERT_R = 8'h60;
    localparam logic [7:0] OPC_INVERT_IND = 8'h61;
    localparam logic [7:0] OPC_CMP_FIRST = 8'ha2;
    localparam logic [7:0] OPC_CMP_SRC_IND_R = 8'ha3;
    localparam logic [7:0] OPC_CMP_SRC_IND = 8'ha5;
    localparam logic [7:0] OPC_CMP_IMM = 8'ha6;
    localparam logic [7:0] OPC_CMP_LAST = 8'ha7;
    localparam logic [7:0] OPC_ADJUST_R = 8'h40;
    localparam logic [7:0] OPC_ADJUST_IND = 8'h41;
    localparam logic [7:0] OPC_BDECR_R = 8'h00;
    localparam logic [7:0] OPC_BDECR_IND = 8'h01;
    localparam logic [7:0] OPC_WDECR_PAIR = 8'h80;
    localparam logic [7:0] OPC_WDECR_IND = 8'h81;
    localparam logic [7:0] BCD_ADD_LO = 8'h06;
    localparam logic [7:0] BCD_ADD_HI = 8'h60;
    localparam logic [7:0] BCD_SUB_LO = 8'hfa;
    localparam logic [7:0] BCD_SUB_HI = 8'ha0;
    localparam logic [7:0] BCD_SUB_BOTH = 8'h9a;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;

    typedef enum logic [2:0] {
        CLS_NONE, CLS_INVERT, CLS_COMPARE, CLS_ADJUST, CLS_BYTE_DECR, CLS_WORD_DECR
    } op_class_t;

    typedef enum logic [1:0] {SRC_REG, SRC_INDIRECT, SRC_IMMEDIATE} src_kind_t;

    function automatic op_class_t op_class(input logic [7:0] opc);
        op_class_t c;
        c = CLS_NONE;
        if (opc == OPC_INVERT_R || opc == OPC_INVERT_IND) c = CLS_INVERT;
        if (opc >= OPC_CMP_FIRST && opc <= OPC_CMP_LAST) c = CLS_COMPARE;
        if (opc == OPC_ADJUST_R || opc == OPC_ADJUST_IND) c = CLS_ADJUST;
        if (opc == OPC_BDECR_R || opc == OPC_BDECR_IND) c = CLS_BYTE_DECR;
        if (opc == OPC_WDECR_PAIR || opc == OPC_WDECR_IND) c = CLS_WORD_DECR;
        return c;
    endfunction

    // destination held in a pointer register
    function automatic logic indirect_register_mode(input logic [7:0] opc);
        return opc == OPC_INVERT_IND || opc == OPC_ADJUST_IND || opc == OPC_BDECR_IND
            || opc == OPC_WDECR_IND || opc == OPC_CMP_LAST;
    endfunction

    function automatic src_kind_t src_kind(input logic [7:0] opc);
        src_kind_t k;
        k = SRC_REG;
        if (opc == OPC_CMP_SRC_IND_R || opc == OPC_CMP_SRC_IND) k = SRC_INDIRECT;
        if (opc == OPC_CMP_IMM || opc == OPC_CMP_LAST) k = SRC_IMMEDIATE;
        return k;
    endfunction

endpackage

// ### rtl/alu_ops_core.sv
// combinational result and flag logic for the five instructions
// assumes operands already fetched; word operand is {high, low}
`timescale 1ns/1ns
module alu_ops_core (
    input wire alu_ops_pkg::op_class_t i_cls,
    input wire logic [15:0] i_opa,
    input wire logic [7:0] i_opb,
    input wire logic [7:0] i_flags,
    output logic [15:0] o_res,
    output logic [7:0] o_flags
);
    import alu_ops_pkg::*;

    logic [8:0] diff;
    logic [3:0] hi_nib;
    logic [3:0] lo_nib;
    logic lo_fix;
    logic hi_fix;
    logic [7:0] adj;

    always_comb begin
        diff = {1'b0, i_opa[7:0]} - {1'b0, i_opb};
        hi_nib = i_opa[7:4];
        lo_nib = i_opa[3:0];
        lo_fix = (lo_nib > BCD_DIGIT_MAX) || i_flags[FLAG_H];
        hi_fix = (hi_nib > BCD_DIGIT_MAX) || i_flags[FLAG_C]
            || (hi_nib == BCD_DIGIT_MAX && lo_nib > BCD_DIGIT_MAX);
        adj = 8'h00;
        o_res = i_opa;
        o_flags = i_flags;
        unique case (i_cls)
            CLS_INVERT: begin
                o_res = {8'h00, ~i_opa[7:0]};
                o_flags[FLAG_V] = 1'b0;
            end
            CLS_COMPARE: begin
                // result only feeds flags; nothing is written back
                o_res = {8'h00, diff[7:0]};
                o_flags[FLAG_C] = diff[8];
                o_flags[FLAG_V] = (i_opa[7] != i_opb[7]) && (diff[7] != i_opa[7]);
            end
            CLS_ADJUST: begin
                if (!i_flags[FLAG_D]) begin
                    adj = (lo_fix ? BCD_ADD_LO : 8'h00) | (hi_fix ? BCD_ADD_HI : 8'h00);
                    o_flags[FLAG_C] = hi_fix;
                end else begin
                    unique case ({i_flags[FLAG_C], i_flags[FLAG_H]})
                        2'b00: adj = 8'h00;
                        2'b01: adj = BCD_SUB_LO;
                        2'b10: adj = BCD_SUB_HI;
                        2'b11: adj = BCD_SUB_BOTH;
                    endcase
                end
                o_res = {8'h00, i_opa[7:0] + adj};
            end
            CLS_BYTE_DECR: begin
                o_res = {8'h00, i_opa[7:0] - 8'h01};
                o_flags[FLAG_V] = (i_opa[7:0] == 8'h80);
            end
            CLS_WORD_DECR: begin
                o_res = i_opa - 16'h0001;
                o_flags[FLAG_V] = (i_opa == 16'h8000);
            end
            default: begin
                o_res = i_opa;
            end
        endcase
        if (i_cls == CLS_WORD_DECR) begin
            o_flags[FLAG_Z] = (o_res == 16'h0000);
            o_flags[FLAG_S] = o_res[15];
        end else if (i_cls != CLS_NONE) begin
            o_flags[FLAG_Z] = (o_res[7:0] == 8'h00);
            o_flags[FLAG_S] = o_res[7];
        end
    end

endmodule

// ### rtl/byte_word_alu_ops.sv
// byte/word alu datapath with its own 256-byte register file and ahb-lite slave
// assumes a single-master ahb-lite bus with word transfers, synchronous reset
//
// Contract
// - complement (60 direct, 61 indirect) writes the inverted destination byte back.
// - complement sets zero and sign from the result, clears overflow, keeps the rest.
// - compare (a2 to a7) subtracts source from destination for flags and writes nothing.
// - compare sets carry from the borrow, zero, sign and overflow; d and h are kept.
// - decimal adjust corrects a byte into two bcd digits, choosing add or sub by the d flag.
// - after an add it adds 06, 60 or 66 by nibble and h/c tests, carry set when 60 is in.
// - after a subtract it adds 00, fa, a0 or 9a by c and h, and carry is kept.
// - decimal adjust sets zero and sign from the adjusted byte; v, d, h are kept.
// - byte decrement (00, 01) writes dst minus one, sets z, s, v and keeps c, d, h.
// - word decrement (80, 81) subtracts one from the 16-bit even-addressed pair.
// - word decrement sets z from all 16 bits, s from bit 15 and v on overflow, keeping c, d and h.
`timescale 1ns/1ns
module byte_word_alu_ops (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic o_busy,
    output logic o_done
);
    import alu_ops_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_RESOLVE, S_EXEC} state_t;

    // ***************************************************
    // storage
    // ***************************************************
    logic [7:0] rf_mem [256];
    logic [7:0] flags_q;
    logic bad_q;
    state_t state_q;
    logic [7:0] opc_q;
    logic [7:0] dst_q;
    logic [7:0] src_q;
    logic [7:0] dst_addr_q;
    logic [7:0] src_addr_q;
    op_class_t cls;

    // ***************************************************
    // ahb-lite slave
    // ***************************************************
    logic wr_pend_q;
    logic rd_pend_q;
    logic [11:0] bus_addr_q;
    logic addr_phase;
    logic bus_wr;
    logic [7:0] rf_idx;
    logic [31:0] rd_mux;

    assign addr_phase = i_hsel && i_htrans[1] && i_hready;
    assign bus_wr = wr_pend_q && i_hready;
    assign rf_idx = bus_addr_q[9:2];

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            bus_addr_q <= 12'h000;
        end else begin
            if (i_hready) begin
                wr_pend_q <= addr_phase && i_hwrite;
                rd_pend_q <= addr_phase && !i_hwrite;
                if (addr_phase) begin
                    bus_addr_q <= i_haddr[11:0];
                end
            end else if (rd_pend_q && o_hreadyout == 1'b0) begin
                rd_pend_q <= 1'b0;
            end
        end
    end

    // reads take one wait state so a write just ahead is always seen
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (bus_addr_q[RF_WINDOW_BIT]) begin
            rd_mux = {24'h00_0000, rf_mem[rf_idx]};
        end else if (bus_addr_q == CMD_OFS) begin
            rd_mux = {8'h00, src_q, dst_q, opc_q};
        end else if (bus_addr_q == FLAGS_OFS) begin
            rd_mux = {24'h00_0000, flags_q};
        end else if (bus_addr_q == STATUS_OFS) begin
            rd_mux[STAT_BUSY_BIT] = (state_q != S_IDLE);
            rd_mux[STAT_BAD_BIT] = bad_q;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_hreadyout <= 1'b1;
            o_hrdata <= 32'h0000_0000;
            o_hresp <= 1'b0;
        end else begin
            o_hresp <= 1'b0;
            if (addr_phase && !i_hwrite) begin
                o_hreadyout <= 1'b0;
            end else if (rd_pend_q && !o_hreadyout) begin
                o_hreadyout <= 1'b1;
                o_hrdata <= rd_mux;
            end
        end
    end

    // ***************************************************
    // sequencer
    // ***************************************************
    logic go;
    logic [7:0] pair_hi;
    logic [7:0] pair_lo;
    logic [15:0] opa;
    logic [7:0] opb;
    logic [15:0] alu_res;
    logic [7:0] alu_flags;

    assign go = bus_wr && !bus_addr_q[RF_WINDOW_BIT] && bus_addr_q == CMD_OFS
        && i_hwdata[CMD_GO_BIT] && state_q == S_IDLE;
    assign cls = op_class(opc_q);
    assign pair_hi = {dst_addr_q[7:1], 1'b0};
    assign pair_lo = {dst_addr_q[7:1], 1'b1};

    always_comb begin
        opb = (src_kind(opc_q) == SRC_IMMEDIATE) ? src_q : rf_mem[src_addr_q];
        if (cls == CLS_WORD_DECR) begin
            opa = {rf_mem[pair_hi], rf_mem[pair_lo]};
        end else begin
            opa = {8'h00, rf_mem[dst_addr_q]};
        end
    end

    alu_ops_core u_core (
        .i_cls(cls),
        .i_opa(opa),
        .i_opb(opb),
        .i_flags(flags_q),
        .o_res(alu_res),
        .o_flags(alu_flags)
    );

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state_q <= S_IDLE;
            opc_q <= 8'h00;
            dst_q <= 8'h00;
            src_q <= 8'h00;
            dst_addr_q <= 8'h00;
            src_addr_q <= 8'h00;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (go) begin
                        opc_q <= i_hwdata[CMD_OPC_LSB +: 8];
                        dst_q <= i_hwdata[CMD_DST_LSB +: 8];
                        src_q <= i_hwdata[CMD_SRC_LSB +: 8];
                        state_q <= S_RESOLVE;
                    end
                end
                S_RESOLVE: begin
                    // pointer register holds the operand address
                    dst_addr_q <= indirect_register_mode(opc_q) ? rf_mem[dst_q] : dst_q;
                    src_addr_q <= (src_kind(opc_q) == SRC_INDIRECT) ? rf_mem[src_q] : src_q;
                    state_q <= (cls == CLS_NONE) ? S_IDLE : S_EXEC;
                end
                S_EXEC: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // register file: bus writes only while idle, so no clash with write-back
    always_ff @(posedge i_ref_clk) begin
        if (state_q == S_EXEC) begin
            unique case (cls)
                CLS_WORD_DECR: begin
                    rf_mem[pair_hi] <= alu_res[15:8];
                    rf_mem[pair_lo] <= alu_res[7:0];
                end
                CLS_INVERT, CLS_ADJUST, CLS_BYTE_DECR: begin
                    rf_mem[dst_addr_q] <= alu_res[7:0];
                end
                default: begin
                    // compare leaves both operands alone
                end
            endcase
        end else if (bus_wr && bus_addr_q[RF_WINDOW_BIT] && state_q == S_IDLE) begin
            rf_mem[rf_idx] <= i_hwdata[7:0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            flags_q <= FLAGS_RST;
        end else if (state_q == S_EXEC) begin
            flags_q <= alu_flags;
        end else if (bus_wr && !bus_addr_q[RF_WINDOW_BIT] && bus_addr_q == FLAGS_OFS
                && state_q == S_IDLE) begin
            flags_q <= i_hwdata[7:0] & FLAGS_MASK;
        end
    end

    // sticky bad-opcode flag, write one to clear; a new set wins
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            bad_q <= 1'b0;
        end else if (state_q == S_RESOLVE && cls == CLS_NONE) begin
            bad_q <= 1'b1;
        end else if (bus_wr && !bus_addr_q[RF_WINDOW_BIT] && bus_addr_q == STATUS_OFS
                && i_hwdata[STAT_BAD_BIT]) begin
            bad_q <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_busy <= go || (state_q == S_RESOLVE && cls != CLS_NONE);
            o_done <= (state_q == S_EXEC);
        end
    end

    // ***************************************************
    // assertions
    // ***************************************************
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);

    invert_result_a: assert property (
        state_q == S_EXEC && cls == CLS_INVERT |=> rf_mem[$past(dst_addr_q)] == ~$past(opa[7:0]))
        else $error("complement did not write the inverted byte");

    invert_flags_a: assert property (
        state_q == S_EXEC && cls == CLS_INVERT
        |=> !flags_q[FLAG_V] && flags_q[FLAG_C] == $past(flags_q[FLAG_C])
            && flags_q[FLAG_S] == rf_mem[$past(dst_addr_q)][7])
        else $error("complement flags wrong");

    compare_keeps_a: assert property (
        state_q == S_EXEC && cls == CLS_COMPARE
        |=> rf_mem[$past(dst_addr_q)] == $past(opa[7:0]))
        else $error("compare modified its destination");

    compare_carry_a: assert property (
        state_q == S_EXEC && cls == CLS_COMPARE
        |=> flags_q[FLAG_C] == ($past(opa[7:0]) < $past(opb))
            && flags_q[FLAG_Z] == ($past(opa[7:0]) == $past(opb)))
        else $error("compare carry or zero wrong");

    adjust_add_a: assert property (
        state_q == S_EXEC && cls == CLS_ADJUST && !flags_q[FLAG_D] && !flags_q[FLAG_C]
        && !flags_q[FLAG_H] && opa[7:4] <= 4'h8 && opa[3:0] > 4'h9
        |=> rf_mem[$past(dst_addr_q)] == $past(opa[7:0]) + 8'h06 && !flags_q[FLAG_C])
        else $error("bcd add correction wrong");

    adjust_sub_a: assert property (
        state_q == S_EXEC && cls == CLS_ADJUST && flags_q[FLAG_D]
        |=> flags_q[FLAG_C] == $past(flags_q[FLAG_C])
            && flags_q[FLAG_V] == $past(flags_q[FLAG_V]))
        else $error("bcd subtract changed carry or overflow");

    byte_decr_a: assert property (
        state_q == S_EXEC && cls == CLS_BYTE_DECR
        |=> rf_mem[$past(dst_addr_q)] == $past(opa[7:0]) - 8'h01
            && flags_q[FLAG_V] == ($past(opa[7:0]) == 8'h80))
        else $error("byte decrement wrong");

    word_decr_a: assert property (
        state_q == S_EXEC && cls == CLS_WORD_DECR
        |=> {rf_mem[$past(pair_hi)], rf_mem[$past(pair_lo)]} == $past(opa) - 16'h0001)
        else $error("word decrement wrong");

    word_flags_a: assert property (
        state_q == S_EXEC && cls == CLS_WORD_DECR
        |=> flags_q[FLAG_S] == rf_mem[$past(pair_hi)][7]
            && flags_q[FLAG_C] == $past(flags_q[FLAG_C]))
        else $error("word decrement flags wrong");

    indirect_fetch_a: assert property (
        state_q == S_RESOLVE && indirect_register_mode(opc_q) && cls != CLS_NONE
        |=> dst_addr_q == $past(rf_mem[dst_q]) ##1 o_done)
        else $error("indirect address not taken from pointer");

    done_timing_a: assert property (
        go |-> ##1 state_q == S_RESOLVE ##[1:2] state_q == S_IDLE)
        else $error("instruction did not finish in time");

    read_wait_a: assert property (
        addr_phase && !i_hwrite && o_hreadyout |=> !o_hreadyout ##1 o_hreadyout)
        else $error("read wait state wrong");

    invert_zero_a: assert property (
        state_q == S_EXEC && cls == CLS_INVERT
        |=> flags_q[FLAG_Z] == (rf_mem[$past(dst_addr_q)] == 8'h00)
            && (flags_q & 8'h0c) == ($past(flags_q) & 8'h0c))
        else $error("complement zero or kept flags wrong");

    compare_kept_a: assert property (
        state_q == S_EXEC && cls == CLS_COMPARE
        |=> (flags_q & 8'h0c) == ($past(flags_q) & 8'h0c))
        else $error("compare changed d or h");

    adjust_flags_a: assert property (
        state_q == S_EXEC && cls == CLS_ADJUST
        |=> flags_q[FLAG_Z] == (rf_mem[$past(dst_addr_q)] == 8'h00)
            && flags_q[FLAG_S] == rf_mem[$past(dst_addr_q)][7]
            && (flags_q & 8'h1c) == ($past(flags_q) & 8'h1c))
        else $error("decimal adjust flags wrong");

    byte_flags_a: assert property (
        state_q == S_EXEC && cls == CLS_BYTE_DECR
        |=> flags_q[FLAG_Z] == (rf_mem[$past(dst_addr_q)] == 8'h00)
            && flags_q[FLAG_S] == rf_mem[$past(dst_addr_q)][7]
            && (flags_q & 8'h8c) == ($past(flags_q) & 8'h8c))
        else $error("byte decrement flags wrong");

    word_zero_a: assert property (
        state_q == S_EXEC && cls == CLS_WORD_DECR
        |=> flags_q[FLAG_Z] == ({rf_mem[$past(pair_hi)], rf_mem[$past(pair_lo)]} == 16'h0000)
            && flags_q[FLAG_V] == (rf_mem[$past(pair_hi)] == 8'h7f
                && rf_mem[$past(pair_lo)] == 8'hff)
            && (flags_q & 8'h8c) == ($past(flags_q) & 8'h8c))
        else $error("word decrement zero, overflow or kept flags wrong");

    busy_window_a: assert property (
        go |=> o_busy && !o_done)
        else $error("busy not raised on go");

    bad_opcode_a: assert property (
        state_q == S_RESOLVE && cls == CLS_NONE |=> bad_q && !o_busy ##1 !o_done)
        else $error("unknown opcode not flagged");

    invert_cov: cover property (state_q == S_EXEC && cls == CLS_INVERT);
    compare_cov: cover property (state_q == S_EXEC && cls == CLS_COMPARE && flags_q[FLAG_C]);
    adjust_cov: cover property (state_q == S_EXEC && cls == CLS_ADJUST && flags_q[FLAG_D]);
    word_cov: cover property (state_q == S_EXEC && cls == CLS_WORD_DECR && opa == 16'h8000);
    bad_cov: cover property (state_q == S_RESOLVE && cls == CLS_NONE);

endmodule

// ### verification/tb_top.sv
// self-checking bench for the byte/word alu datapath, driven over ahb-lite
// assumes the slave answers reads with one wait cycle; hready is fed back from hreadyout
`timescale 1ns/1ns
`define CHK(g, e) check((g), (e))
module tb_top;
    import alu_ops_pkg::*;
    // ****************************************
    // clock, reset, bus signals
    // ****************************************
    logic i_ref_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_hsel = 1'b0;
    logic [31:0] i_haddr = 32'h0;
    logic [1:0] i_htrans = 2'h0;
    logic i_hwrite = 1'b0;
    logic [2:0] i_hsize = 3'h2;
    logic [31:0] i_hwdata = 32'h0;
    logic [31:0] o_hrdata;
    logic o_hreadyout;
    logic o_hresp;
    logic o_busy;
    logic o_done;
    int n_errors = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    always #5 i_ref_clk = ~i_ref_clk;
    byte_word_alu_ops u_dut (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_hsel(i_hsel), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp), .o_busy(o_busy), .o_done(o_done)
    );
    // ****************************************
    // tasks
    // ****************************************
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wait_ready();
        int n;
        for (n = 0; n < 50 && o_hreadyout !== 1'b1; n++) begin
            @(posedge i_ref_clk);
        end
        if (n == 50) begin
            n_errors++;
            stop_test();
        end
    endtask
    // one single word transfer; read data taken at the edge that ends the data phase
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_haddr <= {20'h0, a};
        i_hwrite <= w;
        @(posedge i_ref_clk);
        wait_ready();
        i_htrans <= 2'h0;
        i_hsel <= 1'b0;
        i_hwdata <= wd;
        @(posedge i_ref_clk);
        wait_ready();
        rd = o_hrdata;
        `CHK({31'h0, o_hresp}, 32'h0);
    endtask
    task automatic rf_wr(input logic [7:0] n, input logic [7:0] v);
        ahb(1'b1, 12'h400 + {2'h0, n, 2'h0}, {24'h0, v});
    endtask
    task automatic rf_chk(input logic [7:0] n, input logic [7:0] v);
        ahb(1'b0, 12'h400 + {2'h0, n, 2'h0}, 32'h0);
        `CHK(rd, {24'h0, v});
    endtask
    task automatic set_flags(input logic [7:0] f);
        ahb(1'b1, FLAGS_OFS, {24'h0, f});
    endtask
    task automatic flags_chk(input logic [7:0] f);
        ahb(1'b0, FLAGS_OFS, 32'h0);
        `CHK(rd, {24'h0, f});
    endtask
    // issue one instruction and wait for its done pulse
    task automatic op(input logic [7:0] opc, input logic [7:0] dst, input logic [7:0] src);
        int n;
        ahb(1'b1, CMD_OFS, {1'b1, 7'h0, src, dst, opc});
        @(posedge i_ref_clk);
        `CHK({31'h0, o_busy}, 32'h1);
        for (n = 0; n < 20 && o_done !== 1'b1; n++) begin
            @(posedge i_ref_clk);
        end
        if (n == 20) begin
            n_errors++;
            stop_test();
        end
        `CHK({31'h0, o_busy}, 32'h0);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        @(posedge i_ref_clk);
        flags_chk(FLAGS_RST);
        ahb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rd, 32'h0);
        ahb(1'b0, 12'h00c, 32'h0);
        `CHK(rd, 32'h0);
        $display("test reset done");
        // invert, carry/d/h preset so that keeping them shows
        set_flags(8'h8c);
        rf_wr(8'h08, 8'h24);
        op(OPC_INVERT_R, 8'h08, 8'h00);
        rf_chk(8'h08, 8'hdb);
        flags_chk(8'hac);
        rf_wr(8'h08, 8'h24);
        rf_wr(8'h24, 8'hff);
        op(OPC_INVERT_IND, 8'h08, 8'h00);
        rf_chk(8'h24, 8'h00);
        rf_chk(8'h08, 8'h24);
        flags_chk(8'hcc);
        $display("test invert done");
        // compare: every addressing kind, operands checked to survive after a2 and a7
        set_flags(8'h0c);
        rf_wr(8'h03, 8'h16);
        rf_wr(8'h0b, 8'h20);
        op(8'ha2, 8'h03, 8'h0b);
        flags_chk(8'hac);
        rf_chk(8'h03, 8'h16);
        rf_chk(8'h0b, 8'h20);
        rf_wr(8'h0f, 8'h16);
        rf_wr(8'h2a, 8'h30);
        rf_wr(8'h30, 8'h11);
        op(OPC_CMP_SRC_IND_R, 8'h0f, 8'h2a);
        flags_chk(8'h0c);
        rf_wr(8'h34, 8'h2e);
        rf_wr(8'h12, 8'h1b);
        op(8'ha4, 8'h34, 8'h12);
        flags_chk(8'h0c);
        rf_wr(8'h4b, 8'h82);
        rf_wr(8'h20, 8'h10);
        rf_wr(8'h10, 8'h01);
        op(OPC_CMP_SRC_IND, 8'h4b, 8'h20);
        flags_chk(8'h2c);
        rf_wr(8'h6c, 8'h2a);
        op(OPC_CMP_IMM, 8'h6c, 8'h2a);
        flags_chk(8'h4c);
        rf_wr(8'hd4, 8'hfc);
        rf_wr(8'hfc, 8'h8f);
        op(OPC_CMP_LAST, 8'hd4, 8'h7f);
        flags_chk(8'h1c);
        rf_chk(8'hfc, 8'h8f);
        $display("test compare done");
        // adjust only bytes left by valid bcd sums and differences
        set_flags(8'h00);
        rf_wr(8'h5f, 8'h3c);
        op(OPC_ADJUST_R, 8'h5f, 8'h00);
        rf_chk(8'h5f, 8'h42);
        flags_chk(8'h00);
        rf_wr(8'h5f, 8'h9a);
        op(OPC_ADJUST_R, 8'h5f, 8'h00);
        rf_chk(8'h5f, 8'h00);
        flags_chk(8'hc0);
        set_flags(8'h0c);
        rf_wr(8'h45, 8'h5f);
        rf_wr(8'h5f, 8'h0e);
        op(OPC_ADJUST_IND, 8'h45, 8'h00);
        rf_chk(8'h5f, 8'h08);
        flags_chk(8'h0c);
        set_flags(8'h8c);
        rf_wr(8'h5f, 8'hee);
        op(OPC_ADJUST_R, 8'h5f, 8'h00);
        rf_chk(8'h5f, 8'h88);
        flags_chk(8'hac);
        set_flags(8'h98);
        rf_wr(8'h5f, 8'hf0);
        op(OPC_ADJUST_R, 8'h5f, 8'h00);
        rf_chk(8'h5f, 8'h90);
        flags_chk(8'hb8);
        $display("test adjust done");
        // byte decrement: signed overflow edge and indirect zero
        set_flags(8'h8c);
        rf_wr(8'h2a, 8'h80);
        op(OPC_BDECR_R, 8'h2a, 8'h00);
        rf_chk(8'h2a, 8'h7f);
        flags_chk(8'h9c);
        rf_wr(8'hb3, 8'hcb);
        rf_wr(8'hcb, 8'h01);
        op(OPC_BDECR_IND, 8'hb3, 8'h00);
        rf_chk(8'hcb, 8'h00);
        flags_chk(8'hcc);
        $display("test byte decrement done");
        // word decrement: odd address folds to the even pair, borrow crosses bytes
        set_flags(8'h8c);
        rf_wr(8'h30, 8'h0a);
        rf_wr(8'h31, 8'hf2);
        op(OPC_WDECR_PAIR, 8'h31, 8'h00);
        rf_chk(8'h30, 8'h0a);
        rf_chk(8'h31, 8'hf1);
        flags_chk(8'h8c);
        rf_wr(8'h30, 8'h80);
        rf_wr(8'h31, 8'h00);
        op(OPC_WDECR_PAIR, 8'h30, 8'h00);
        rf_chk(8'h30, 8'h7f);
        rf_chk(8'h31, 8'hff);
        flags_chk(8'h9c);
        rf_wr(8'h20, 8'h30);
        rf_wr(8'h31, 8'h01);
        rf_wr(8'h30, 8'h00);
        op(OPC_WDECR_IND, 8'h20, 8'h00);
        rf_chk(8'h31, 8'h00);
        flags_chk(8'hcc);
        $display("test word decrement done");
        // unknown opcode: nothing runs, status flags it until cleared
        ahb(1'b1, CMD_OFS, 32'h8000_0002);
        repeat (3) @(posedge i_ref_clk);
        ahb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rd, 32'h0000_0002);
        ahb(1'b1, STATUS_OFS, 32'h0000_0002);
        ahb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rd, 32'h0000_0000);
        ahb(1'b0, CMD_OFS, 32'h0);
        `CHK(rd, 32'h0000_0002);
        $display("test bad opcode done");
        stop_test();
    end
endmodule
